// [common/host_status_interrupt_regs_regs.vh]
`ifndef HOST_STATUS_INTERRUPT_REGS_REGS_VH
`define HOST_STATUS_INTERRUPT_REGS_REGS_VH

// Register byte offsets
`define OFF_DEST_X        14'h1cb0
`define OFF_LIN_SRC_Y     14'h1e00
`define OFF_BYTE_ACC      14'h1e08
`define OFF_ADDR_GEN      14'h1e0c
`define OFF_FIFO_STAT     14'h1e10
`define OFF_EVT_STATUS    14'h1e14
`define OFF_EVT_CLEAR     14'h1e18
`define OFF_EVT_ENABLE    14'h1e1c
`define OFF_PCI_IRQ       14'h1e28
`define OFF_SOFT_RESET    14'h1e40
`define OFF_TEST_CTRL     14'h1e44
`define OFF_IDENTITY      14'h1e48
`define OFF_BOARD_CFG     14'h1e50

// Field positions
`define ST_FULL_BIT       8
`define ST_EMPTY_BIT      9
`define ST_BUSY_BIT       16
`define TEST_ROWREN_BIT   8
`define TEST_TSTWREN_BIT  9
`define CFG_BIOS_BIT      9
`define CFG_VGAEN_BIT     10
`define CFG_ABOVE1M_BIT   12
`define CFG_MAPSEL_LSB    24
`define CFG_PCI_BIT       27
`define CFG_ISA_BIT       28
`define PCI_EXT_BIT       1

// Values
`define ROWREN_KEY        8'h8d
`define FIFO_FREE_RESET   6'h20
`define BE_BYTE0_ONLY     4'h1
`define CFG_WIDE16        2'h1
`define CFG_NARROW16      2'h3
`define FIFO_STAT_RESET   10'h220
`define MAPSEL_NONE       3'h0
`define MAPSEL_LEGACY     3'h1

// Decode windows for the 16-bit select (ROM) and the wide 32-bit select (REG)
`define ROM_LA            7'h06
`define ROM_SA_HI         3'h1
`define REG_LA            7'h07
`define REG_SA            3'h0

// Wait timeout in core clocks (50 ns each)
`define WAIT_ERR_CYC      8'h40
`define WAIT_ABORT_CYC    8'h80

`endif

// [hw/host_status_interrupt_regs.v]
// What this block does
// - Destination X holds a 16-bit signed coordinate; upper written bits ignored.
// - Engine loads destination X from left or right boundary itself.
// - Linear source Y low five bits always read zero; software writes multiples of 32.
// - Direct frame access address is source Y divided by four plus host address bits 12:2.
// - Free-count field shows unused FIFO entries, 32 after reset, stable readback.
// - Status bits 8 and 9 show FIFO full and empty.
// - Non-legacy wait over 64 clocks sets bus error; 128 clocks aborts cycle.
// - Enabled DMA terminal count sets bit 1 until cleared by software.
// - Picking event sets bit 2 until software clears it.
// - Status bit 3 follows vertical sync directly, no latch.
// - Status bit 16 shows drawing engine busy.
// - Writing one to clear bits 0..2 clears matching status; zero does nothing.
// - Enable bits 0..2 gate interrupts; DMA count only while DMA active.
// - Enable bit 3 passes vertical sync only when legacy video disabled.
// - PCI register bit 1 latches external interrupt edge, cleared by writing one.
// - PCI register bit 0 reads zero when this device interrupts.
// - Soft reset bit resets host registers except board configuration and test write permission (test bit 9) synchronously until written zero.
// - Key 10001101 in test byte 3 permits writes to straps-held bits.
// - Test write permission set at reset if frame line 38 low.
// - Bus-width bits load from straps; rewritten only by byte-0-only write.
// - With config bit 1 set, 16-bit select decodes LA and SA narrow windows.
// - Legacy video is 8-bit; ROM width follows BIOS enable and config.
`timescale 1ns/1ps
`default_nettype none
`include "host_status_interrupt_regs_regs.vh"

module host_status_interrupt_regs #(
  parameter [31:0] ID_VALUE = 32'h5a5a_0003 // Arbitrary identity value
) (
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire [13:0] host_addr_i,
  input  wire        host_wr_i,
  input  wire        host_rd_i,
  input  wire [3:0]  host_be_i,
  input  wire [31:0] host_wdata_i,
  output reg  [31:0] host_rdata_o,
  input  wire        direct_access_i,
  output reg  [21:0] vram_addr_o,
  input  wire        xdst_load_left_i,
  input  wire        xdst_load_right_i,
  input  wire [15:0] fx_left_i,
  input  wire [15:0] fx_right_i,
  input  wire [5:0]  fifo_free_i,
  input  wire        fifo_full_i,
  input  wire        fifo_empty_i,
  input  wire        engine_busy_i,
  input  wire        wait_active_i,
  input  wire        legacy_target_i,
  output reg         cycle_abort_o,
  input  wire        dma_tc_i,
  input  wire        dma_transfer_active_i,
  input  wire        pick_event_i,
  input  wire        vsync_i,
  input  wire        ext_irq_input_n_i,
  output reg         host_irq_o,
  output reg         soft_reset_o,
  output reg         ram_test_o,
  output reg         vga_test_o,
  input  wire [1:0]  strap_config_i,
  input  wire [2:0]  strap_mapsel_i,
  input  wire        strap_pci_i,
  input  wire        strap_isa_i,
  input  wire        strap_above1m_i,
  input  wire        strap_vgaen_i,
  input  wire        frame_data_line_38_i,
  input  wire [23:17] isa_la_i,
  input  wire [16:14] isa_sa_i,
  input  wire        legacy_access_i,
  output reg         isa_16bit_select_n_o,
  output reg         wide_32bit_select_n_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [15:0] xdst_reg;
  reg [23:5] srcy_reg;
  reg [9:0]  fifo_stat_reg;
  reg        bferr_reg;
  reg        dmatc_reg;
  reg        pick_reg;
  reg [3:0]  ien_reg;
  reg        ext_irq_reg;
  reg        ext_in_reg;
  reg        soft_reg;
  reg        rowren_reg;
  reg        tstwren_reg;
  reg        strap_done_reg;
  reg [1:0]  cfg_width_reg;
  reg        biosen_reg;
  reg        vgaen_reg;
  reg        above1m_reg;
  reg [2:0]  mapsel_reg;
  reg        pci_reg;
  reg        isa_reg;
  reg [7:0]  wait_cnt_reg;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire wr_xdst   = host_wr_i && (host_addr_i == `OFF_DEST_X);
  wire wr_srcy   = host_wr_i && (host_addr_i == `OFF_LIN_SRC_Y);
  wire wr_clr    = host_wr_i && (host_addr_i == `OFF_EVT_CLEAR);
  wire wr_ien    = host_wr_i && (host_addr_i == `OFF_EVT_ENABLE);
  wire wr_pci    = host_wr_i && (host_addr_i == `OFF_PCI_IRQ);
  wire wr_soft   = host_wr_i && (host_addr_i == `OFF_SOFT_RESET);
  wire wr_test   = host_wr_i && (host_addr_i == `OFF_TEST_CTRL);
  wire wr_cfg    = host_wr_i && (host_addr_i == `OFF_BOARD_CFG);

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  wire ext_fall  = ext_in_reg && !ext_irq_input_n_i;
  wire tc_set    = dma_tc_i && ien_reg[1] && dma_transfer_active_i;
  wire wait_err  = wait_active_i && !legacy_target_i;
  wire vs_pass   = vsync_i && ien_reg[3] && !vgaen_reg;
  wire irq_next  = (bferr_reg && ien_reg[0]) || (dmatc_reg && ien_reg[1]) ||
                   (pick_reg && ien_reg[2]) || vs_pass;
  wire stat_full = fifo_stat_reg[`ST_FULL_BIT];

  // ----------------------------------------
  // Soft reset and straps
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_reg       <= 1'b0;
      strap_done_reg <= 1'b0;
      tstwren_reg    <= 1'b0;
      ext_in_reg     <= 1'b1;
    end else begin
      ext_in_reg <= ext_irq_input_n_i;
      if (wr_soft && host_be_i[0]) begin
        soft_reg <= host_wdata_i[0];
      end
      if (!strap_done_reg) begin
        strap_done_reg <= 1'b1;
        tstwren_reg    <= !frame_data_line_38_i;
      end
    end
  end

  // ----------------------------------------
  // Host registers
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xdst_reg      <= 16'h0000;
      srcy_reg      <= 19'h00000;
      fifo_stat_reg <= `FIFO_STAT_RESET;
      bferr_reg     <= 1'b0;
      dmatc_reg     <= 1'b0;
      pick_reg      <= 1'b0;
      ien_reg       <= 4'h0;
      ext_irq_reg   <= 1'b0;
      rowren_reg    <= 1'b0;
      ram_test_o    <= 1'b0;
      vga_test_o    <= 1'b0;
      cfg_width_reg <= 2'h0;
      biosen_reg    <= 1'b0;
      vgaen_reg     <= 1'b0;
      above1m_reg   <= 1'b0;
      mapsel_reg    <= 3'h0;
      pci_reg       <= 1'b0;
      isa_reg       <= 1'b0;
      wait_cnt_reg  <= 8'h00;
      cycle_abort_o <= 1'b0;
    end else if (!strap_done_reg) begin
      cfg_width_reg <= strap_config_i;
      mapsel_reg    <= strap_mapsel_i;
      pci_reg       <= strap_pci_i;
      isa_reg       <= strap_isa_i;
      above1m_reg   <= strap_above1m_i;
      vgaen_reg     <= strap_vgaen_i;
      biosen_reg    <= strap_vgaen_i;
    end else if (soft_reg) begin
      xdst_reg      <= 16'h0000;
      srcy_reg      <= 19'h00000;
      fifo_stat_reg <= `FIFO_STAT_RESET;
      bferr_reg     <= 1'b0;
      dmatc_reg     <= 1'b0;
      pick_reg      <= 1'b0;
      ien_reg       <= 4'h0;
      ext_irq_reg   <= 1'b0;
      rowren_reg    <= 1'b0;
      ram_test_o    <= 1'b0;
      vga_test_o    <= 1'b0;
      wait_cnt_reg  <= 8'h00;
      cycle_abort_o <= 1'b0;
    end else begin
      // Destination X
      if (xdst_load_left_i) begin
        xdst_reg <= fx_left_i;
      end else if (xdst_load_right_i) begin
        xdst_reg <= fx_right_i;
      end else if (wr_xdst) begin
        if (host_be_i[0]) xdst_reg[7:0]  <= host_wdata_i[7:0];
        if (host_be_i[1]) xdst_reg[15:8] <= host_wdata_i[15:8];
      end
      // Linear source Y, low five bits never stored
      if (wr_srcy) begin
        if (host_be_i[0]) srcy_reg[7:5]   <= host_wdata_i[7:5];
        if (host_be_i[1]) srcy_reg[15:8]  <= host_wdata_i[15:8];
        if (host_be_i[2]) srcy_reg[23:16] <= host_wdata_i[23:16];
      end
      // FIFO status sampled as one word
      fifo_stat_reg <= {fifo_empty_i, fifo_full_i, 2'b00, fifo_free_i};
      // Wait timeout
      if (wait_err) begin
        if (wait_cnt_reg != `WAIT_ABORT_CYC) begin
          wait_cnt_reg <= wait_cnt_reg + 8'h01;
        end
      end else begin
        wait_cnt_reg <= 8'h00;
      end
      cycle_abort_o <= wait_err && (wait_cnt_reg == `WAIT_ABORT_CYC - 8'h01);
      // Sticky events: set wins over clear
      if (wait_err && (wait_cnt_reg >= `WAIT_ERR_CYC)) begin
        bferr_reg <= 1'b1;
      end else if (wr_clr && host_be_i[0] && host_wdata_i[0]) begin
        bferr_reg <= 1'b0;
      end
      if (tc_set) begin
        dmatc_reg <= 1'b1;
      end else if (wr_clr && host_be_i[0] && host_wdata_i[1]) begin
        dmatc_reg <= 1'b0;
      end
      if (pick_event_i) begin
        pick_reg <= 1'b1;
      end else if (wr_clr && host_be_i[0] && host_wdata_i[2]) begin
        pick_reg <= 1'b0;
      end
      if (wr_ien && host_be_i[0]) begin
        ien_reg <= host_wdata_i[3:0];
      end
      // External interrupt edge, PCI builds only
      if (pci_reg && ext_fall) begin
        ext_irq_reg <= 1'b1;
      end else if (wr_pci && host_be_i[0] && host_wdata_i[`PCI_EXT_BIT]) begin
        ext_irq_reg <= 1'b0;
      end
      // Test register
      if (wr_test && host_be_i[3] && (host_wdata_i[31:24] == `ROWREN_KEY)) begin
        rowren_reg <= 1'b1;
      end
      if (wr_test && host_be_i[0] && tstwren_reg) begin
        vga_test_o <= host_wdata_i[0];
        ram_test_o <= host_wdata_i[1];
      end
      // Board configuration
      if (wr_cfg && (host_be_i == `BE_BYTE0_ONLY)) begin
        cfg_width_reg <= host_wdata_i[1:0];
      end
      if (wr_cfg && host_be_i[1]) begin
        biosen_reg <= host_wdata_i[`CFG_BIOS_BIT];
        vgaen_reg  <= host_wdata_i[`CFG_VGAEN_BIT];
        if (rowren_reg) above1m_reg <= host_wdata_i[`CFG_ABOVE1M_BIT];
      end
      if (wr_cfg && host_be_i[3] && rowren_reg) begin
        mapsel_reg <= host_wdata_i[`CFG_MAPSEL_LSB+2:`CFG_MAPSEL_LSB];
        pci_reg    <= host_wdata_i[`CFG_PCI_BIT];
        isa_reg    <= host_wdata_i[`CFG_ISA_BIT];
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg [31:0] rdata_next;
  always @* begin
    rdata_next = 32'h0000_0000;
    if (host_addr_i == `OFF_DEST_X) begin
      rdata_next = {16'h0000, xdst_reg};
    end else if (host_addr_i == `OFF_LIN_SRC_Y) begin
      rdata_next = {8'h00, srcy_reg, 5'h00};
    end else if (host_addr_i == `OFF_BYTE_ACC) begin
      rdata_next = 32'h0000_0000; // Test-only data
    end else if (host_addr_i == `OFF_ADDR_GEN) begin
      rdata_next = 32'h0000_0000;
    end else if (host_addr_i == `OFF_FIFO_STAT) begin
      rdata_next = {22'h000000, fifo_stat_reg};
    end else if (host_addr_i == `OFF_EVT_STATUS) begin
      rdata_next = {15'h0000, engine_busy_i, 12'h000,
                    vsync_i, pick_reg, dmatc_reg, bferr_reg};
    end else if (host_addr_i == `OFF_EVT_ENABLE) begin
      rdata_next = {28'h0000000, ien_reg};
    end else if (host_addr_i == `OFF_PCI_IRQ) begin
      if (pci_reg) rdata_next = {30'h00000000, ext_irq_reg, !host_irq_o};
    end else if (host_addr_i == `OFF_SOFT_RESET) begin
      rdata_next = {31'h00000000, soft_reg};
    end else if (host_addr_i == `OFF_TEST_CTRL) begin
      rdata_next = {22'h000000, tstwren_reg, rowren_reg, 6'h00, ram_test_o, vga_test_o};
    end else if (host_addr_i == `OFF_IDENTITY) begin
      rdata_next = ID_VALUE;
    end else if (host_addr_i == `OFF_BOARD_CFG) begin
      rdata_next = {3'h0, isa_reg, pci_reg, mapsel_reg, 11'h000, above1m_reg, 1'b0,
                    vgaen_reg, biosen_reg, 7'h00, cfg_width_reg};
    end
  end

  // ----------------------------------------
  // Address decode for ISA select lines
  // ----------------------------------------
  wire rom_hit = (isa_la_i == `ROM_LA) &&
                 (!cfg_width_reg[1] || (isa_sa_i <= `ROM_SA_HI));
  wire reg_hit = (isa_la_i == `REG_LA) &&
                 (!cfg_width_reg[1] || (isa_sa_i == `REG_SA));
  wire cfg16   = (cfg_width_reg == `CFG_WIDE16) ||
                 (cfg_width_reg == `CFG_NARROW16);
  wire rom16   = biosen_reg && cfg16 && rom_hit;
  wire wide32  = reg_hit && (mapsel_reg != `MAPSEL_NONE) &&
                 !((mapsel_reg == `MAPSEL_LEGACY) && vgaen_reg);

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_rdata_o          <= 32'h0000_0000;
      vram_addr_o           <= 22'h000000;
      host_irq_o            <= 1'b0;
      soft_reset_o          <= 1'b0;
    end else begin
      if (host_rd_i) host_rdata_o <= rdata_next;
      if (direct_access_i) begin
        vram_addr_o <= {srcy_reg, 3'b000} + {11'h000, host_addr_i[12:2]};
      end
      host_irq_o            <= irq_next && !soft_reg;
      soft_reset_o          <= soft_reg;
    end
  end

  // ----------------------------------------
  // Select line flops
  // ----------------------------------------
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      isa_16bit_select_n_o  <= 1'b1;
      wide_32bit_select_n_o <= 1'b1;
    end else begin
      isa_16bit_select_n_o  <= !(rom16 && !legacy_access_i);
      wide_32bit_select_n_o <= !(wide32 && !legacy_access_i);
    end
  end

  wire unused_ok = stat_full & isa_sa_i[16] & 1'b0;

endmodule
`default_nettype wire

// [verif/host_status_interrupt_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "host_status_interrupt_regs_regs.vh"
module host_status_interrupt_regs_props (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [13:0] host_addr_i,
  input wire logic        host_rd_i,
  input wire logic [31:0] host_rdata_o,
  input wire logic [5:0]  fifo_free_i,
  input wire logic        vsync_i,
  input wire logic        engine_busy_i,
  input wire logic        wait_active_i,
  input wire logic        legacy_target_i,
  input wire logic        cycle_abort_o,
  input wire logic        host_irq_o,
  input wire logic        soft_reset_o,
  input wire logic        legacy_access_i,
  input wire logic        isa_16bit_select_n_o,
  input wire logic        wide_32bit_select_n_o
);
  // ------------------------------
  // Wait counter
  // ------------------------------
  logic [7:0] wait_cnt;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      wait_cnt <= 8'h00;
    else if (wait_active_i && !legacy_target_i)
      wait_cnt <= wait_cnt + 8'h01;
    else
      wait_cnt <= 8'h00;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ------------------------------
  // Assertions
  // ------------------------------
  a_abort_at_limit: assert property (
    cycle_abort_o |-> wait_cnt >= 8'd127 && wait_cnt <= 8'd129) else $error("abort timing");
  a_abort_one_pulse: assert property (
    cycle_abort_o |=> !cycle_abort_o) else $error("abort too long");
  a_srcy_low_zero: assert property (
    host_rd_i && host_addr_i == `OFF_LIN_SRC_Y |=> host_rdata_o[4:0] == 5'h00
    && host_rdata_o[31:24] == 8'h00) else $error("source y bits");
  a_fifo_count_read: assert property (
    host_rd_i && host_addr_i == `OFF_FIFO_STAT && !soft_reset_o
    |=> host_rdata_o[5:0] == $past(fifo_free_i, 2)) else $error("free count");
  a_legacy_8bit: assert property (
    legacy_access_i |=> isa_16bit_select_n_o && wide_32bit_select_n_o)
    else $error("legacy select");
  a_vsync_live: assert property (
    host_rd_i && host_addr_i == `OFF_EVT_STATUS
    |=> host_rdata_o[3] == $past(vsync_i)) else $error("vsync status");
  a_busy_live: assert property (
    host_rd_i && host_addr_i == `OFF_EVT_STATUS
    |=> host_rdata_o[16] == $past(engine_busy_i)) else $error("busy status");
  a_unmapped_zero: assert property (
    host_rd_i && host_addr_i == 14'h1e04 |=> host_rdata_o == 32'h0) else $error("unmapped");
  a_rdata_holds: assert property (
    !host_rd_i && !soft_reset_o |=> $stable(host_rdata_o)) else $error("rdata moved");
  a_soft_irq_low: assert property (
    soft_reset_o && $past(soft_reset_o) |-> !host_irq_o) else $error("irq in reset");
  c_abort: cover property (cycle_abort_o);
  c_irq: cover property (host_irq_o);
  c_soft: cover property (soft_reset_o);
endmodule
bind host_status_interrupt_regs host_status_interrupt_regs_props u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .host_addr_i(host_addr_i),
  .host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o), .fifo_free_i(fifo_free_i),
  .vsync_i(vsync_i), .engine_busy_i(engine_busy_i), .wait_active_i(wait_active_i),
  .legacy_target_i(legacy_target_i), .cycle_abort_o(cycle_abort_o),
  .host_irq_o(host_irq_o), .soft_reset_o(soft_reset_o),
  .legacy_access_i(legacy_access_i), .isa_16bit_select_n_o(isa_16bit_select_n_o),
  .wide_32bit_select_n_o(wide_32bit_select_n_o));
`default_nettype wire

// [verif/host_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  output var  logic [13:0] addr_o,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [3:0]  be_o,
  output var  logic [31:0] wdata_o
);
  initial begin
    addr_o = 14'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    be_o = 4'h0;
    wdata_o = 32'h0;
  end
  task wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] b);
    addr_o = a;
    wdata_o = d;
    be_o = b;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1 wr_o = 1'b0;
    wdata_o = ~d;
    @(posedge clk_i);
    #1;
  endtask
  task rd(input logic [13:0] a, output logic [31:0] d);
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1 rd_o = 1'b0;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask
  task point(input logic [13:0] a);
    addr_o = a;
  endtask
endmodule
`default_nettype wire

// [verif/host_status_interrupt_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "host_status_interrupt_regs_regs.vh"
module host_status_interrupt_regs_tb_top;
  logic        clk_i, reset_n_i, wr, rd, dir, ld_l, ld_r, full, empty, busy;
  logic        wt, leg, tc, act, pick, vs, eirq_n, abort, irq, srst, ramt, vgat;
  logic [13:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata;
  logic [15:0] fx_l, fx_r;
  logic [5:0]  free;
  logic [21:0] vaddr;
  logic [1:0]  scfg;
  logic [2:0]  smap, sa;
  logic [6:0]  la;
  logic        spci, svga, fd38, lacc, sel16_n, sel32_n;
  int          fail_count, total_checks;
  host_bus_model u_host_bus_model (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr),
    .wr_o(wr), .rd_o(rd), .be_o(be), .wdata_o(wdata));
  host_status_interrupt_regs u_host_status_interrupt_regs (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .host_addr_i(addr), .host_wr_i(wr),
    .host_rd_i(rd), .host_be_i(be), .host_wdata_i(wdata), .host_rdata_o(rdata),
    .direct_access_i(dir), .vram_addr_o(vaddr), .xdst_load_left_i(ld_l),
    .xdst_load_right_i(ld_r), .fx_left_i(fx_l), .fx_right_i(fx_r),
    .fifo_free_i(free), .fifo_full_i(full), .fifo_empty_i(empty),
    .engine_busy_i(busy), .wait_active_i(wt), .legacy_target_i(leg),
    .cycle_abort_o(abort), .dma_tc_i(tc), .dma_transfer_active_i(act),
    .pick_event_i(pick), .vsync_i(vs), .ext_irq_input_n_i(eirq_n),
    .host_irq_o(irq), .soft_reset_o(srst), .ram_test_o(ramt), .vga_test_o(vgat),
    .strap_config_i(scfg), .strap_mapsel_i(smap), .strap_pci_i(spci),
    .strap_isa_i(1'b0), .strap_above1m_i(1'b0), .strap_vgaen_i(svga),
    .frame_data_line_38_i(fd38), .isa_la_i(la), .isa_sa_i(sa),
    .legacy_access_i(lacc), .isa_16bit_select_n_o(sel16_n),
    .wide_32bit_select_n_o(sel32_n));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ------------------------------
  // Helpers
  // ------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rdc(input logic [13:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    u_host_bus_model.rd(a, d);
    chk(d & m, e);
  endtask
  task ev(input bit dma);
    if (dma)
      tc = 1'b1;
    else
      pick = 1'b1;
    @(posedge clk_i);
    #1 tc = 1'b0;
    pick = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  task waitn(input bit lg, input int e);
    int n;
    n = 0;
    leg = lg;
    wt = 1'b1;
    repeat (130) begin
      @(posedge clk_i);
      #1 n += abort;
    end
    wt = 1'b0;
    chk(n, e);
  endtask
  task stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  task t_regs;
    rdc(`OFF_EVT_ENABLE, 32'hffffffff, 32'h0);
    rdc(`OFF_FIFO_STAT, 32'h33f, 32'h220);
    rdc(`OFF_TEST_CTRL, 32'h300, 32'h200);
    rdc(14'h1e04, 32'hffffffff, 32'h0);
    u_host_bus_model.wr(`OFF_DEST_X, 32'hffff8001, 4'hf);
    rdc(`OFF_DEST_X, 32'hffffffff, 32'h8001);
    fx_l = 16'h1234;
    fx_r = 16'h8765;
    ld_l = 1'b1;
    @(posedge clk_i);
    #1 ld_l = 1'b0;
    rdc(`OFF_DEST_X, 32'hffff, 32'h1234);
    ld_r = 1'b1;
    @(posedge clk_i);
    #1 ld_r = 1'b0;
    rdc(`OFF_DEST_X, 32'hffff, 32'h8765);
    u_host_bus_model.wr(`OFF_LIN_SRC_Y, 32'hff12345f, 4'hf);
    rdc(`OFF_LIN_SRC_Y, 32'hffffffff, 32'h00123440);
    u_host_bus_model.point(14'h1ffc);
    dir = 1'b1;
    @(posedge clk_i);
    #1 chk({10'h0, vaddr}, 32'h0004950f);
    dir = 1'b0;
    $display("test registers done");
  endtask
  task t_fifo;
    free = 6'h00;
    full = 1'b1;
    empty = 1'b0;
    busy = 1'b1;
    @(posedge clk_i);
    #1 rdc(`OFF_FIFO_STAT, 32'h33f, 32'h100);
    rdc(`OFF_EVT_STATUS, 32'h10000, 32'h10000);
    free = 6'h11;
    full = 1'b0;
    busy = 1'b0;
    @(posedge clk_i);
    #1 rdc(`OFF_FIFO_STAT, 32'h33f, 32'h011);
    rdc(`OFF_EVT_STATUS, 32'h10000, 32'h0);
    $display("test fifo done");
  endtask
  task t_events;
    u_host_bus_model.wr(`OFF_EVT_ENABLE, 32'h7, 4'hf);
    vs = 1'b1;
    rdc(`OFF_EVT_STATUS, 32'hf, 32'h8);
    vs = 1'b0;
    rdc(`OFF_EVT_STATUS, 32'hf, 32'h0);
    ev(1'b0);
    chk(irq, 32'h1);
    u_host_bus_model.wr(`OFF_EVT_CLEAR, 32'h0, 4'hf);
    rdc(`OFF_EVT_STATUS, 32'hf, 32'h4);
    u_host_bus_model.wr(`OFF_EVT_CLEAR, 32'h4, 4'hf);
    rdc(`OFF_EVT_STATUS, 32'hf, 32'h0);
    chk(irq, 32'h0);
    act = 1'b1;
    ev(1'b1);
    rdc(`OFF_EVT_STATUS, 32'hf, 32'h2);
    u_host_bus_model.wr(`OFF_EVT_CLEAR, 32'h2, 4'hf);
    rdc(`OFF_EVT_STATUS, 32'hf, 32'h0);
    u_host_bus_model.wr(`OFF_EVT_ENABLE, 32'h3, 4'hf);
    ev(1'b0);
    rdc(`OFF_EVT_STATUS, 32'hf, 32'h4);
    chk(irq, 32'h0);
    u_host_bus_model.wr(`OFF_EVT_CLEAR, 32'h4, 4'hf);
    waitn(1'b1, 0);
    rdc(`OFF_EVT_STATUS, 32'h1, 32'h0);
    waitn(1'b0, 1);
    rdc(`OFF_EVT_STATUS, 32'h1, 32'h1);
    chk(irq, 32'h1);
    u_host_bus_model.wr(`OFF_EVT_CLEAR, 32'h1, 4'hf);
    rdc(`OFF_EVT_STATUS, 32'h1, 32'h0);
    $display("test events done");
  endtask
  task t_pci_cfg;
    eirq_n = 1'b0;
    @(posedge clk_i);
    #1 eirq_n = 1'b1;
    rdc(`OFF_PCI_IRQ, 32'h3, 32'h3);
    u_host_bus_model.wr(`OFF_PCI_IRQ, 32'h0, 4'hf);
    rdc(`OFF_PCI_IRQ, 32'h2, 32'h2);
    u_host_bus_model.wr(`OFF_PCI_IRQ, 32'h2, 4'hf);
    rdc(`OFF_PCI_IRQ, 32'h2, 32'h0);
    u_host_bus_model.wr(`OFF_BOARD_CFG, 32'h1, 4'h1);
    rdc(`OFF_BOARD_CFG, 32'h3, 32'h1);
    u_host_bus_model.wr(`OFF_BOARD_CFG, 32'h602, 4'h3);
    rdc(`OFF_BOARD_CFG, 32'h3, 32'h1);
    u_host_bus_model.wr(`OFF_TEST_CTRL, 32'h8d000000, 4'h8);
    rdc(`OFF_TEST_CTRL, 32'h100, 32'h100);
    u_host_bus_model.wr(`OFF_TEST_CTRL, 32'h3, 4'h1);
    chk({ramt, vgat}, 32'h3);
    $display("test pci and config done");
  endtask
  task t_soft;
    u_host_bus_model.wr(`OFF_EVT_ENABLE, 32'h4, 4'hf);
    ev(1'b0);
    u_host_bus_model.wr(`OFF_SOFT_RESET, 32'h1, 4'hf);
    chk({srst, irq}, 32'h2);
    rdc(`OFF_EVT_ENABLE, 32'hffffffff, 32'h0);
    u_host_bus_model.wr(`OFF_SOFT_RESET, 32'h0, 4'hf);
    chk(srst, 32'h0);
    $display("test soft reset done");
  endtask
  task dec(input logic [6:0] l, input logic [2:0] s, input logic a);
    la = l;
    sa = s;
    lacc = a;
    @(posedge clk_i);
    #1;
  endtask
  task t_decode;
    dec(7'h06, 3'h0, 1'b0);
    chk(sel16_n, 32'h0);
    dec(7'h06, 3'h0, 1'b1);
    chk({sel16_n, sel32_n}, 32'h3);
    dec(7'h07, 3'h0, 1'b0);
    chk(sel32_n, 32'h1);
    u_host_bus_model.wr(`OFF_EVT_ENABLE, 32'h8, 4'h1);
    vs = 1'b1;
    @(posedge clk_i);
    #1 chk(irq, 32'h0);
    vs = 1'b0;
    reset_n_i = 1'b0;
    {scfg, svga, fd38} = {2'h3, 1'b0, 1'b1};
    repeat (2) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    @(posedge clk_i);
    #1 rdc(`OFF_TEST_CTRL, 32'h300, 32'h0);
    u_host_bus_model.wr(`OFF_TEST_CTRL, 32'h3, 4'h1);
    chk({ramt, vgat}, 32'h0);
    rdc(`OFF_BOARD_CFG, 32'h603, 32'h3);
    dec(7'h06, 3'h1, 1'b0);
    chk(sel16_n, 32'h1);
    dec(7'h07, 3'h0, 1'b0);
    chk(sel32_n, 32'h0);
    u_host_bus_model.wr(`OFF_BOARD_CFG, 32'h200, 4'h2);
    dec(7'h06, 3'h1, 1'b0);
    chk(sel16_n, 32'h0);
    dec(7'h06, 3'h4, 1'b0);
    chk(sel16_n, 32'h1);
    u_host_bus_model.wr(`OFF_EVT_ENABLE, 32'h8, 4'h1);
    vs = 1'b1;
    @(posedge clk_i);
    #1 chk(irq, 32'h1);
    vs = 1'b0;
    @(posedge clk_i);
    #1 chk(irq, 32'h0);
    $display("test decode done");
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    reset_n_i = 1'b0;
    {dir, ld_l, ld_r, full, busy, wt, leg, tc, act, pick, vs} = '0;
    empty = 1'b1;
    eirq_n = 1'b1;
    free = 6'h20;
    {scfg, smap, spci, svga} = {2'h0, 3'h1, 1'b1, 1'b1};
    {fd38, la, sa, lacc} = '0;
    fx_l = 16'h0;
    fx_r = 16'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    @(posedge clk_i);
    #1 t_regs();
    t_fifo();
    t_events();
    t_pci_cfg();
    t_soft();
    t_decode();
    stop_test();
  end
  initial begin
    #(50 * 8000);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
